//--- include/deploy_status_consts.svh
// Constants for the deploy status monitor: frame layout, reset values, timing
`ifndef DEPLOY_STATUS_CONSTS_SVH
`define DEPLOY_STATUS_CONSTS_SVH

`define FRAME_W            16
`define CHAN_N             4

// Frame field positions
`define BIT_MODE_HI        15
`define BIT_MODE_LO        14
`define BIT_PARITY         13
`define BIT_SEL_HI         12
`define BIT_SEL_LO         9
`define BIT_REPORT_SEL     8
`define BIT_RSVD_HI        7
`define BIT_RSVD_LO        4
`define BIT_CHAN_HI        3
`define BIT_CHAN_LO        0

// Header values of a monitor-mode-1 frame
`define HDR_MODE           2'h3
`define HDR_SEL            4'h0
`define RSVD_ZERO          4'h0

// Reset values
`define REPORT_SEL_RST     1'h0
`define FLAGS_RST          4'h0
`define RESP_RST           16'h0000

// Deployment time in microseconds and derived cycle count at the core clock
`define CLK_MHZ            20
`define T_DEPLOY_US        1000
`define DEPLOY_CYCLES      (`T_DEPLOY_US * `CLK_MHZ)
`define DEPLOY_CNT_W       16

`endif

//--- include/deploy_status_pkg.sv
// Types shared by the deploy status monitor testbench and the channel trackers
package deploy_status_pkg;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_WAIT_ENABLE,
        CH_FIRE
    } chan_state_t;

    typedef logic [15:0] frame_t;

endpackage

//--- logic/deploy_channel.sv
// One squib channel: deploy-active and deploy-done flags with the firing timer
`timescale 1ns/1ps
`include "deploy_status_consts.svh"

module deploy_channel #(
    parameter logic [`DEPLOY_CNT_W-1:0] LAST_CNT = 16'h4E1F
) (
    input  wire logic sys_clk_i,
    input  wire logic arst_n_i,
    input  wire logic fire_req_i,
    input  wire logic fire_enable_function_i,
    input  wire logic low_side_driver_fault_i,
    input  wire logic clear_done_i,
    output logic      fire_drive_o,
    output logic      deploy_active_flag_o,
    output logic      deploy_done_flag_o
);

    deploy_status_pkg::chan_state_t state;
    deploy_status_pkg::chan_state_t next_state;
    logic [`DEPLOY_CNT_W-1:0]       cnt;
    logic                           cut;

    wire timer_end  = (cnt == LAST_CNT);
    // A set done flag locks the channel out of new deployments
    wire start      = (state == deploy_status_pkg::CH_IDLE) && fire_req_i
                      && !deploy_done_flag_o;
    wire fire_end   = (state == deploy_status_pkg::CH_FIRE) && timer_end;
    wire lsd_trip   = (state == deploy_status_pkg::CH_FIRE) && low_side_driver_fault_i && !cut;
    // Set beats a clear in the same cycle so a completion is never lost
    wire done_set   = fire_end || lsd_trip;
    wire next_done  = done_set || (deploy_done_flag_o && !clear_done_i);
    wire enter_fire = fire_enable_function_i &&
                      ((state == deploy_status_pkg::CH_IDLE && start) ||
                       state == deploy_status_pkg::CH_WAIT_ENABLE);
    // Wait counts from zero so an unenabled request still stands one full deployment time
    wire cnt_clr    = enter_fire || (state == deploy_status_pkg::CH_IDLE)
                      || (next_state == deploy_status_pkg::CH_IDLE);

    always_comb begin
        next_state = state;
        unique case (state)
            deploy_status_pkg::CH_IDLE: begin
                if (start) begin
                    next_state = fire_enable_function_i ? deploy_status_pkg::CH_FIRE
                                                        : deploy_status_pkg::CH_WAIT_ENABLE;
                end
            end
            deploy_status_pkg::CH_WAIT_ENABLE: begin
                if (fire_enable_function_i) begin
                    next_state = deploy_status_pkg::CH_FIRE;
                end else if (timer_end) begin
                    next_state = deploy_status_pkg::CH_IDLE;
                end
            end
            deploy_status_pkg::CH_FIRE: begin
                if (timer_end) begin
                    next_state = deploy_status_pkg::CH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= deploy_status_pkg::CH_IDLE;
            cnt   <= '0;
            cut   <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= cnt_clr ? '0 : cnt + 1'b1;
            cut   <= (state == deploy_status_pkg::CH_FIRE) && (cut || low_side_driver_fault_i);
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            deploy_done_flag_o   <= 1'b0;
            deploy_active_flag_o <= 1'b0;
            fire_drive_o         <= 1'b0;
        end else begin
            deploy_done_flag_o   <= next_done;
            // Active rises on any valid request, enable or not
            deploy_active_flag_o <= (next_state != deploy_status_pkg::CH_IDLE);
            fire_drive_o         <= (next_state == deploy_status_pkg::CH_FIRE) && !cut
                                    && !lsd_trip;
        end
    end

    // Run length of the active flag, read only by the checks below
    logic [`DEPLOY_CNT_W:0] act_len;
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            act_len <= '0;
        end else begin
            act_len <= deploy_active_flag_o ? act_len + 1'b1 : '0;
        end
    end

    a_active_max_len: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        act_len <= {1'b0, LAST_CNT} + {1'b0, LAST_CNT} + 2)
        else $error("active flag held beyond two deployment times");

    a_fire_min_len: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $fell(deploy_active_flag_o) && $past(state) == deploy_status_pkg::CH_FIRE
        |-> $past(act_len) >= {1'b0, LAST_CNT})
        else $error("active flag shorter than one deployment time");

    a_wait_min_len: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        $fell(deploy_active_flag_o) && $past(state) == deploy_status_pkg::CH_WAIT_ENABLE
        |-> $past(act_len) >= {1'b0, LAST_CNT})
        else $error("unenabled wait shorter than one deployment time");

    a_timeout_drop: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        fire_end |=> !deploy_active_flag_o && deploy_done_flag_o)
        else $error("active flag not dropped or done not set at timeout");

    a_start_active: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        start |=> deploy_active_flag_o)
        else $error("valid fire request did not raise active flag");

endmodule // deploy_channel

//--- logic/deploy_status_monitor.sv
// Monitor-mode-1 frame interpreter and status reporter for four squib channels
`timescale 1ns/1ps
`include "deploy_status_consts.svh"

module deploy_status_monitor #(
    parameter int unsigned DEPLOY_CYCLES = `DEPLOY_CYCLES
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 cs_deploy_n_i,
    input  wire logic                 cmd_valid_i,
    input  wire logic [`FRAME_W-1:0]  cmd_data_i,
    input  wire logic [`CHAN_N-1:0]   fire_req_i,
    input  wire logic [`CHAN_N-1:0]   fire_enable_function_i,
    input  wire logic [`CHAN_N-1:0]   low_side_driver_fault_i,
    output logic      [`FRAME_W-1:0]  resp_data_o,
    output logic                      resp_valid_o,
    output logic                      cmd_error_o,
    output logic      [`CHAN_N-1:0]   fire_drive_o,
    output logic      [`CHAN_N-1:0]   deploy_active_flag_o,
    output logic      [`CHAN_N-1:0]   deploy_done_flag_o
);

    localparam logic [`DEPLOY_CNT_W-1:0] LAST_CNT = `DEPLOY_CNT_W'(DEPLOY_CYCLES - 1);

    // Chip select comes from a pin: two stages before anything looks at it
    logic cs_meta;
    logic cs_sync;
    logic cs_prev;
    logic report_sel;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
        end else begin
            cs_meta <= cs_deploy_n_i;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
        end
    end

    wire cs_fall = cs_prev && !cs_sync;

    // Frame decode
    wire hdr_ok   = (cmd_data_i[`BIT_MODE_HI:`BIT_MODE_LO] == `HDR_MODE) &&
                    (cmd_data_i[`BIT_SEL_HI:`BIT_SEL_LO] == `HDR_SEL);
    wire par_ok   = ^cmd_data_i;
    wire cmd_good = cmd_valid_i && hdr_ok && par_ok;
    wire cmd_bad  = cmd_valid_i && hdr_ok && !par_ok;
    // Reserved command bits D7:D4 count only toward parity and are never checked for zero
    wire [`CHAN_N-1:0] clear_vec = cmd_good ? cmd_data_i[`BIT_CHAN_HI:`BIT_CHAN_LO]
                                            : `FLAGS_RST;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            report_sel  <= `REPORT_SEL_RST;
            cmd_error_o <= 1'b0;
        end else begin
            if (cmd_good) begin
                report_sel <= cmd_data_i[`BIT_REPORT_SEL];
            end
            cmd_error_o <= cmd_bad;
        end
    end

    // Answer word; parity bit chosen so the full word has an odd count of ones
    wire [`CHAN_N-1:0] chan_status = report_sel ? deploy_active_flag_o
                                                : deploy_done_flag_o;
    wire [`FRAME_W-1:0] resp_base = {`HDR_MODE, 1'b0, `HDR_SEL, report_sel,
                                     `RSVD_ZERO, chan_status};
    wire resp_par = ~^resp_base;
    wire [`FRAME_W-1:0] resp_word = {resp_base[`FRAME_W-1:`BIT_PARITY+1], resp_par,
                                     resp_base[`BIT_PARITY-1:0]};

    // Snapshot at select fall so the shifter sends a stable word all frame long
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            resp_data_o  <= `RESP_RST;
            resp_valid_o <= 1'b0;
        end else begin
            if (cs_fall) begin
                resp_data_o <= resp_word;
            end
            resp_valid_o <= cs_fall;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < `CHAN_N; ch++) begin : g_chan
            deploy_channel #(
                .LAST_CNT (LAST_CNT)
            ) u_chan (
                .sys_clk_i               (sys_clk_i),
                .arst_n_i                (arst_n_i),
                .fire_req_i              (fire_req_i[ch]),
                .fire_enable_function_i  (fire_enable_function_i[ch]),
                .low_side_driver_fault_i (low_side_driver_fault_i[ch]),
                .clear_done_i            (clear_vec[ch]),
                .fire_drive_o            (fire_drive_o[ch]),
                .deploy_active_flag_o    (deploy_active_flag_o[ch]),
                .deploy_done_flag_o      (deploy_done_flag_o[ch])
            );
        end
    endgenerate

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    sequence s_good_cmd;
        cmd_valid_i && hdr_ok && par_ok;
    endsequence

    sequence s_capture;
        cs_fall ##1 resp_valid_o;
    endsequence

    a_sel_stored: assert property (
        s_good_cmd |=> report_sel == $past(cmd_data_i[`BIT_REPORT_SEL]))
        else $error("report choice not stored from good command");

    a_bad_parity_kept: assert property (
        cmd_bad |=> report_sel == $past(report_sel) && cmd_error_o)
        else $error("bad parity frame changed state or was not flagged");

    a_resp_header: assert property (
        resp_valid_o |-> resp_data_o[`BIT_MODE_HI:`BIT_MODE_LO] == `HDR_MODE &&
                         resp_data_o[`BIT_SEL_HI:`BIT_SEL_LO] == `HDR_SEL)
        else $error("answer header wrong");

    a_resp_parity: assert property (
        resp_valid_o |-> ^resp_data_o)
        else $error("answer parity not odd");

    a_resp_sel_echo: assert property (
        s_capture |-> resp_data_o[`BIT_REPORT_SEL] == $past(report_sel))
        else $error("answer D8 not the stored choice");

    a_resp_flags: assert property (
        cs_fall |=> resp_data_o[`BIT_CHAN_HI:`BIT_CHAN_LO] ==
                    ($past(report_sel) ? $past(deploy_active_flag_o)
                                       : $past(deploy_done_flag_o)))
        else $error("answer channel bits wrong");

    a_resp_reserved: assert property (
        resp_valid_o |-> resp_data_o[`BIT_RSVD_HI:`BIT_RSVD_LO] == `RSVD_ZERO)
        else $error("answer D7:D4 not zero");

    a_clear_done: assert property (
        s_good_cmd ##0 (deploy_active_flag_o == `FLAGS_RST)
        |=> (deploy_done_flag_o & $past(cmd_data_i[`BIT_CHAN_HI:`BIT_CHAN_LO])) == `FLAGS_RST)
        else $error("done flag not cleared by command");

    a_done_sticky: assert property (
        !cmd_good |=> ($past(deploy_done_flag_o) & ~deploy_done_flag_o) == `FLAGS_RST)
        else $error("done flag fell without a clear");

    a_refuse_redeploy: assert property (
        (deploy_done_flag_o & fire_req_i & ~deploy_active_flag_o) != `FLAGS_RST
        |=> ($past(deploy_done_flag_o & fire_req_i & ~deploy_active_flag_o)
             & deploy_active_flag_o) == `FLAGS_RST)
        else $error("deployment started while done flag set");

    a_drive_in_active: assert property (
        (fire_drive_o & ~deploy_active_flag_o) == `FLAGS_RST)
        else $error("driver on while channel not active");

endmodule // deploy_status_monitor

//--- verification/spi_master_model.sv
// Frame-level SPI master model: chip select, command word, answer capture
`timescale 1ns/1ps

module spi_master_model (
    input  wire logic        sys_clk_i,
    input  wire logic [15:0] resp_data_i,
    input  wire logic        resp_valid_i,
    input  wire logic        cmd_error_i,
    output logic             cs_deploy_n_o,
    output logic             cmd_valid_o,
    output logic [15:0]      cmd_data_o
);
    initial begin
        cs_deploy_n_o = 1'h1;
        cmd_valid_o = 1'h0;
        cmd_data_o = 16'h0000;
    end

    // Select, take the answer, hand over the command, then deselect
    task automatic xfer(input logic [15:0] word, input logic bad,
                        output logic [15:0] rsp, output logic ok, output logic err);
        logic [15:0] w;
        w = word;
        w[13] = ~^{w[15:14], w[12:0]};
        if (bad) w[13] = ~w[13];
        ok = 1'h0;
        err = 1'h0;
        rsp = 16'h0000;
        @(posedge sys_clk_i);
        cs_deploy_n_o <= 1'h0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(posedge sys_clk_i);
            if (resp_valid_i === 1'h1) begin
                ok = 1'h1;
                rsp = resp_data_i;
            end
        end
        cmd_valid_o <= 1'h1;
        cmd_data_o <= w;
        @(posedge sys_clk_i);
        cmd_valid_o <= 1'h0;
        // Stale data would hide a decoder that ignores the strobe
        cmd_data_o <= ~w;
        cs_deploy_n_o <= 1'h1;
        repeat (3) begin
            @(posedge sys_clk_i);
            err = err | (cmd_error_i === 1'h1);
        end
    endtask
endmodule // spi_master_model

//--- verification/deploy_status_monitor_tb.sv
// Self-checking testbench for the deploy status monitor
`timescale 1ns/1ps

module deploy_status_monitor_tb;
    localparam int unsigned DC = 8;
    logic        sys_clk_i = 1'h0;
    logic        arst_n_i = 1'h0;
    logic        cs_n;
    logic        cmd_valid;
    logic        cmd_error;
    logic        resp_valid;
    logic [15:0] cmd_data;
    logic [15:0] resp_data;
    logic [3:0]  fire_req = 4'h0;
    logic [3:0]  fire_enable_function = 4'h0;
    logic [3:0]  low_side_driver = 4'h0;
    logic [3:0]  drive;
    logic [3:0]  active;
    logic [3:0]  done;
    logic        sel = 1'h0;
    logic        ok;
    logic        err;
    int          error_cnt = 0;
    int          samples_checked = 0;
    deploy_status_pkg::frame_t rsp;

    always #25 sys_clk_i = ~sys_clk_i;

    deploy_status_monitor #(.DEPLOY_CYCLES(DC)) u_deploy_status_monitor (
        .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .cs_deploy_n_i(cs_n),
        .cmd_valid_i(cmd_valid), .cmd_data_i(cmd_data), .fire_req_i(fire_req),
        .fire_enable_function_i(fire_enable_function), .low_side_driver_fault_i(low_side_driver),
        .resp_data_o(resp_data), .resp_valid_o(resp_valid), .cmd_error_o(cmd_error),
        .fire_drive_o(drive), .deploy_active_flag_o(active), .deploy_done_flag_o(done));

    spi_master_model u_spi_master_model (
        .sys_clk_i(sys_clk_i), .resp_data_i(resp_data), .resp_valid_i(resp_valid),
        .cmd_error_i(cmd_error), .cs_deploy_n_o(cs_n), .cmd_valid_o(cmd_valid),
        .cmd_data_o(cmd_data));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    function automatic deploy_status_pkg::frame_t exp_resp(input logic s, input logic [3:0] f);
        deploy_status_pkg::frame_t w;
        w = {2'h3, 1'h0, 4'h0, s, 4'h0, f};
        w[13] = ~^w;
        return w;
    endfunction

    // Answer reflects the choice stored before this frame's command lands
    task automatic xfer(input logic s, input logic [3:0] clr, input logic [3:0] junk,
                        input logic bad, input logic [3:0] f);
        u_spi_master_model.xfer({2'h3, 1'h0, 4'h0, s, junk, clr}, bad, rsp, ok, err);
        check(ok, 1'h1, "no answer");
        if (!ok) report_and_stop();
        check(rsp, exp_resp(sel, f), "answer word");
        check(err, bad, "parity error pulse");
        if (!bad) sel = s;
    endtask

    task automatic pulse_fire(input int ch, input logic en);
        @(posedge sys_clk_i);
        fire_req[ch] <= 1'h1;
        fire_enable_function[ch] <= en;
        @(posedge sys_clk_i);
        fire_req[ch] <= 1'h0;
        #1;
    endtask

    task automatic wait_fall(input int ch);
        int n;
        n = 0;
        while (active[ch] === 1'h1 && n < 2 * DC) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check(active[ch], 1'h0, "active flag stuck");
        if (active[ch] !== 1'h0) report_and_stop();
    endtask

    task automatic t_reset();
        check({cmd_error, resp_valid, drive, active, done}, 14'h0000, "reset outputs");
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'h0);
    endtask

    task automatic t_fire_done();
        pulse_fire(0, 1'h1);
        check({active[0], drive[0]}, 2'h3, "fire start");
        repeat (DC - 1) @(posedge sys_clk_i);
        #1;
        check({active[0], done[0]}, 2'h2, "last fire cycle");
        @(posedge sys_clk_i);
        #1;
        check({active[0], done[0], drive[0]}, 3'h2, "fire end");
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'h1);
    endtask

    task automatic t_refuse_clear();
        pulse_fire(0, 1'h1);
        check(active[0], 1'h0, "refire while done");
        xfer(1'h0, 4'h1, 4'hF, 1'h0, 4'h1);
        check(done, 4'h0, "done cleared");
        pulse_fire(0, 1'h1);
        check(active[0], 1'h1, "refire after clear");
        wait_fall(0);
        check(done[0], 1'h1, "second fire done");
    endtask

    task automatic t_select();
        xfer(1'h1, 4'h0, 4'h0, 1'h0, 4'h1);
        pulse_fire(1, 1'h1);
        xfer(1'h1, 4'h0, 4'h0, 1'h0, 4'h2);
        wait_fall(1);
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'h0);
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'h3);
    endtask

    task automatic t_parity();
        xfer(1'h1, 4'hF, 4'h0, 1'h1, 4'h3);
        check(done, 4'h3, "bad frame kept flags");
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'h3);
    endtask

    task automatic t_no_enable();
        pulse_fire(2, 1'h0);
        check(active[2], 1'h1, "rise without enable");
        repeat (DC - 1) @(posedge sys_clk_i);
        #1;
        check({active[2], drive[2]}, 2'h2, "waiting for enable");
        wait_fall(2);
        check(done[2], 1'h0, "timeout without fire");
    endtask

    task automatic t_fault();
        pulse_fire(3, 1'h1);
        @(posedge sys_clk_i);
        low_side_driver[3] <= 1'h1;
        @(posedge sys_clk_i);
        #1;
        check({active[3], done[3], drive[3]}, 3'h6, "shutdown state");
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'hB);
        low_side_driver[3] <= 1'h0;
        wait_fall(3);
    endtask

    // Reset in mid-run with flags set and the active-flag report chosen
    task automatic t_mid_reset();
        xfer(1'h1, 4'h0, 4'h0, 1'h0, 4'hB);
        arst_n_i <= 1'h0;
        repeat (2) @(posedge sys_clk_i);
        arst_n_i <= 1'h1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        sel = 1'h0;
        check({cmd_error, resp_valid, drive, active, done}, 14'h0000, "mid-run reset");
        xfer(1'h0, 4'h0, 4'h0, 1'h0, 4'h0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk_i);
        arst_n_i <= 1'h1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        t_reset();
        t_fire_done();
        t_refuse_clear();
        t_select();
        t_parity();
        t_no_enable();
        t_fault();
        t_mid_reset();
        report_and_stop();
    end
endmodule // deploy_status_monitor_tb
